// ---- core/fts_top.v ----
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fts_defs.vh"

module fts_top #(
  parameter [15:0] TICK_CYC = `FTS_TICK_CYC,
  parameter [15:0] MIN_TICKS = `FTS_MIN_TICKS,
  parameter [18:0] WARM_TICKS = `FTS_WARM_TICKS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire adc_valid,
  input wire [9:0] adc_front,
  input wire [9:0] adc_center,
  input wire [9:0] adc_rear,
  input wire [9:0] adc_press,
  input wire print_req,
  input wire print_busy,
  input wire [4:0] nv_cnt_in,
  input wire [15:0] nv_code_in,
  output reg [4:0] nv_cnt_out,
  output reg [15:0] nv_code_out,
  output reg nv_wr,
  output reg induction_heating_coil_en,
  output reg ready,
  output reg copy_pause,
  output reg lamp_en,
  output reg panel_en,
  output reg motor_en,
  output reg machine_power_en
);

  localparam [7:0] S_LOAD = 8'h01;
  localparam [7:0] S_WARM = 8'h02;
  localparam [7:0] S_READY = 8'h04;
  localparam [7:0] S_WAIT = 8'h08;
  localparam [7:0] S_SAVE = 8'h10;
  localparam [7:0] S_OFF = 8'h20;
  localparam [7:0] S_FAULT = 8'h40;
  localparam [7:0] S_SHUT = 8'h80;

  // Piecewise-linear calibration; slopes are degrees per code, Q8.
  function [8:0] fts_temp;
    input [9:0] c;
    reg [9:0] d;
    reg [7:0] s;
    reg [8:0] b;
    reg [17:0] p;
    begin
      if (c < `FTS_C0) begin
        b = 9'h000; d = c; s = 8'h64;
      end else if (c < `FTS_C1) begin
        b = 9'h028; d = c - `FTS_C0; s = 8'h32;
      end else if (c < `FTS_C2) begin
        b = 9'h064; d = c - `FTS_C1; s = 8'h36;
      end else if (c < `FTS_C3) begin
        b = 9'h0A0; d = c - `FTS_C2; s = 8'h3E;
      end else if (c < `FTS_C4) begin
        b = 9'h0AA; d = c - `FTS_C3; s = 8'h60;
      end else begin
        b = 9'h0B9; d = c - `FTS_C4; s = 8'h5E;
      end
      p = d * s;
      fts_temp = b + p[16:8];
    end
  endfunction

  // Address decode shared by the error answer and the write strobe.
  function fts_hit;
    input [7:0] a;
    begin
      fts_hit = (a[1:0] == 2'h0) && (a <= `FTS_A_TMPB);
    end
  endfunction

  reg [7:0] state;
  reg loaded;
  reg got;
  reg [9:0] c_front;
  reg [9:0] c_center;
  reg [9:0] c_rear;
  reg [9:0] c_press;
  reg [15:0] tick_cnt;
  reg tick;
  reg high_speed;
  reg [7:0] save_min;
  reg [7:0] off_min;
  reg [4:0] err_cnt;
  reg [15:0] fcode;
  reg [15:0] min_sub;
  reg [7:0] min_cnt;
  reg [18:0] warm_cnt;
  reg shut_stage;

  wire [8:0] t_front = fts_temp(c_front);
  wire [8:0] t_center = fts_temp(c_center);
  wire [8:0] t_rear = fts_temp(c_rear);
  wire [8:0] t_press = fts_temp(c_press);
  // Control uses the cooler of front and rear so neither zone runs away.
  wire [8:0] t_ctrl = (t_front < t_rear) ? t_front : t_rear;
  wire [8:0] t_low = high_speed ? `FTS_T_LOW_HS : `FTS_T_LOW;
  wire front_hot = t_front >= `FTS_T_FRONT_HOT;
  wire hot_roll = (t_center >= `FTS_T_CENTER_HOT) |
    (t_rear >= `FTS_T_REAR_HOT) | front_hot;
  wire hot_press = t_press >= `FTS_T_PRESS_HOT;
  // A broken thermistor reads near zero volts, which looks very cold.
  wire open_any = (c_front < `FTS_OPEN_CODE) |
    (c_center < `FTS_OPEN_CODE) | (c_rear < `FTS_OPEN_CODE) |
    (c_press < `FTS_OPEN_CODE);
  wire corrupt = err_cnt >= `FTS_CNT_MAX;
  wire eval = tick & got;
  wire apb_wr = psel & penable & pwrite & fts_hit(paddr);
  wire idle_run = (state == S_READY || state == S_WAIT ||
    state == S_SAVE) & ~print_busy & ~print_req;
  wire heat_state = (state == S_WARM) | (state == S_READY) |
    (state == S_WAIT);

  assign pready = 1'b1;
  assign pslverr = psel & penable & (~fts_hit(paddr) |
    (pwrite & (paddr == `FTS_A_CNT) & (pwdata >= `FTS_CNT_MAX)));

  // Sample codes on the converter strobe; the converter shares pclk.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_front <= 10'h000;
      c_center <= 10'h000;
      c_rear <= 10'h000;
      c_press <= 10'h000;
      got <= 1'b0;
    end else if (adc_valid) begin
      c_front <= adc_front;
      c_center <= adc_center;
      c_rear <= adc_rear;
      c_press <= adc_press;
      got <= 1'b1;
    end
  end

  // Periodic sample tick from the system clock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYC - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Settings, error counter and the supervisory state machine.
  // Software writes come first so a hardware event in the same cycle
  // overrides them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_LOAD;
      loaded <= 1'b0;
      high_speed <= 1'b0;
      save_min <= `FTS_SAVE_RST;
      off_min <= `FTS_OFF_RST;
      err_cnt <= 5'h00;
      fcode <= 16'h0000;
      min_sub <= 16'h0000;
      min_cnt <= 8'h00;
      warm_cnt <= 19'h00000;
      shut_stage <= 1'b0;
      nv_wr <= 1'b0;
    end else begin
      nv_wr <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `FTS_A_CTRL: begin
            high_speed <= pwdata[0];
          end
          `FTS_A_SAVE: begin
            save_min <= pwdata[7:0];
          end
          `FTS_A_OFF: begin
            off_min <= pwdata[7:0];
          end
          `FTS_A_CNT: begin
            if (pwdata < `FTS_CNT_MAX) begin
              err_cnt <= pwdata[4:0];
              nv_wr <= 1'b1;
              if (pwdata[4:0] == 5'h00) begin
                fcode <= 16'h0000;
                if (state == S_FAULT)
                  state <= S_WARM;
              end
            end
          end
          default: begin
          end
        endcase
      end
      // Idle minutes run only while nothing is being printed.
      if (!idle_run) begin
        min_sub <= 16'h0000;
        min_cnt <= 8'h00;
      end else if (tick) begin
        if (min_sub == MIN_TICKS - 16'h0001) begin
          min_sub <= 16'h0000;
          if (min_cnt != 8'hFF)
            min_cnt <= min_cnt + 8'h01;
        end else begin
          min_sub <= min_sub + 16'h0001;
        end
      end
      if (state != S_WARM)
        warm_cnt <= 19'h00000;
      else if (tick && warm_cnt != WARM_TICKS)
        warm_cnt <= warm_cnt + 19'h00001;
      case (state)
        S_LOAD: begin
          if (!loaded) begin
            err_cnt <= nv_cnt_in;
            fcode <= nv_code_in;
            loaded <= 1'b1;
          end else if (eval) begin
            if (corrupt) begin
              state <= S_FAULT;
            end else if (err_cnt >= `FTS_CNT_BLOCK) begin
              state <= S_FAULT;
              if (err_cnt == `FTS_CNT_BLOCK)
                fcode <= `FTS_CODE_WARM2;
            end else begin
              state <= S_WARM;
            end
          end
        end
        S_WARM: begin
          if (eval && t_ctrl >= `FTS_T_READY) begin
            state <= S_READY;
            if (err_cnt <= 5'h01) begin
              err_cnt <= 5'h00;
              nv_wr <= 1'b1;
            end
          end else if (warm_cnt == WARM_TICKS) begin
            state <= S_FAULT;
            nv_wr <= 1'b1;
            if (err_cnt == 5'h00) begin
              err_cnt <= 5'h01;
              fcode <= `FTS_CODE_WARM1;
            end else begin
              err_cnt <= `FTS_CNT_BLOCK;
              fcode <= `FTS_CODE_WARM2;
            end
          end
        end
        S_READY: begin
          if (eval && t_ctrl <= t_low) begin
            state <= S_WAIT;
          end else if (tick && min_cnt >= save_min) begin
            state <= S_SAVE;
            min_sub <= 16'h0000;
            min_cnt <= 8'h00;
          end
        end
        S_WAIT: begin
          if (eval && t_ctrl > t_low)
            state <= S_READY;
        end
        S_SAVE: begin
          if (print_req) begin
            state <= S_WARM;
          end else if (tick && min_cnt >= off_min) begin
            state <= S_OFF;
          end
        end
        S_OFF: begin
          if (print_req)
            state <= S_WARM;
        end
        S_SHUT: begin
          if (tick)
            shut_stage <= 1'b1;
        end
        S_FAULT: begin
        end
        default: begin
          state <= S_LOAD;
        end
      endcase
      // Overheat outranks everything, also right after power-up.
      if (eval && loaded && state != S_SHUT) begin
        if (hot_roll) begin
          state <= S_SHUT;
          err_cnt <= `FTS_CNT_HOT;
          fcode <= `FTS_CODE_HOT;
          nv_wr <= 1'b1;
        end else if (hot_press) begin
          state <= S_SHUT;
          err_cnt <= `FTS_CNT_PRESS;
          fcode <= `FTS_CODE_PRESS;
          nv_wr <= 1'b1;
        end else if (open_any && state != S_LOAD) begin
          state <= S_FAULT;
          fcode <= `FTS_CODE_OPEN;
          nv_wr <= 1'b1;
        end
      end
    end
  end

  // Outputs follow the state one cycle later; outside heating the coil is forced off
  // at once, else it is only re-judged on a tick, so it cannot chatter between samples.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      induction_heating_coil_en <= 1'b0;
      ready <= 1'b0;
      copy_pause <= 1'b0;
      lamp_en <= 1'b0;
      panel_en <= 1'b0;
      motor_en <= 1'b0;
      machine_power_en <= 1'b1;
      nv_cnt_out <= 5'h00;
      nv_code_out <= 16'h0000;
    end else begin
      if (!heat_state || state == S_SHUT || corrupt) begin
        induction_heating_coil_en <= 1'b0;
      end else if (eval) begin
        induction_heating_coil_en <= loaded & ~open_any & ~front_hot &
          (t_ctrl < `FTS_T_READY);
      end
      ready <= (state == S_READY);
      copy_pause <= (state == S_WAIT);
      lamp_en <= (state != S_SHUT);
      panel_en <= (state != S_SHUT);
      motor_en <= (state != S_SHUT);
      machine_power_en <= ~((state == S_SHUT) & shut_stage);
      nv_cnt_out <= err_cnt;
      nv_code_out <= fcode;
    end
  end

  // Read data is loaded in the setup phase and stands in the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        `FTS_A_CTRL: prdata <= {31'h00000000, high_speed};
        `FTS_A_SAVE: prdata <= {24'h000000, save_min};
        `FTS_A_OFF: prdata <= {24'h000000, off_min};
        `FTS_A_CNT: prdata <= {27'h0000000, err_cnt};
        `FTS_A_STAT: prdata <= {11'h000, err_cnt, 5'h00, corrupt,
          got, induction_heating_coil_en, state};
        `FTS_A_CODE: prdata <= {16'h0000, fcode};
        `FTS_A_TMPA: prdata <= {7'h00, t_rear, 7'h00, t_front};
        `FTS_A_TMPB: prdata <= {7'h00, t_press, 7'h00, t_center};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // fts_top

// ---- core/fts_defs.vh ----
`ifndef FTS_DEFS_VH
`define FTS_DEFS_VH

// Register byte offsets.
`define FTS_A_CTRL 8'h00
`define FTS_A_SAVE 8'h04
`define FTS_A_OFF 8'h08
`define FTS_A_CNT 8'h0C
`define FTS_A_STAT 8'h10
`define FTS_A_CODE 8'h14
`define FTS_A_TMPA 8'h18
`define FTS_A_TMPB 8'h1C
// Reset values of the idle settings in minutes.
`define FTS_SAVE_RST 8'h0F
`define FTS_OFF_RST 8'h5A
// Temperature thresholds in degrees.
`define FTS_T_READY 9'h0C8
`define FTS_T_LOW_HS 9'h0AA
`define FTS_T_LOW 9'h0A0
`define FTS_T_CENTER_HOT 9'h0F0
`define FTS_T_REAR_HOT 9'h0FA
`define FTS_T_FRONT_HOT 9'h10E
`define FTS_T_PRESS_HOT 9'h0FA
// Calibration breakpoints (10-bit code, 5 V full scale) and the open-sensor code.
`define FTS_C0 10'h066
`define FTS_C1 10'h199
`define FTS_C2 10'h2B8
`define FTS_C3 10'h2E1
`define FTS_C4 10'h309
`define FTS_OPEN_CODE 10'h010
// Error counter limits and codes.
`define FTS_CNT_MAX 32'h0000001E
`define FTS_CNT_BLOCK 5'h02
`define FTS_CNT_HOT 5'h09
`define FTS_CNT_PRESS 5'h08
`define FTS_CODE_HOT 16'hC449
`define FTS_CODE_PRESS 16'hC468
`define FTS_CODE_WARM1 16'hC411
`define FTS_CODE_WARM2 16'hC412
`define FTS_CODE_OPEN 16'hC440
// Timing: a 1 ms sample tick at 40 MHz, ticks per minute and the
// 300 s warm-up limit, sized to the counters that hold them.
`define FTS_TICK_CYC 16'h9C40
`define FTS_MIN_TICKS 16'hEA60
`define FTS_WARM_TICKS 19'h493E0
`endif

// ---- tb/fts_chk.sv ----
`timescale 1ns/1ps
module fts_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire [4:0] nv_cnt_out,
  input wire [15:0] nv_code_out,
  input wire nv_wr,
  input wire induction_heating_coil_en,
  input wire ready,
  input wire lamp_en,
  input wire panel_en,
  input wire motor_en,
  input wire machine_power_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Everything that a shutdown must switch off before power goes.
  sequence s_all_off;
    !induction_heating_coil_en && !lamp_en && !panel_en && !motor_en;
  endsequence
  sequence s_hot_rec;
    nv_code_out == 16'hC449 && nv_cnt_out == 5'h09;
  endsequence
  // Power removal is the last step, so outputs were already off a cycle ago.
  a_off_before_cut: assert property (
    $fell(machine_power_en) |-> s_all_off
    ##0 (!$past(lamp_en) && !$past(induction_heating_coil_en)))
    else $error("machine power cut before outputs off");
  a_outputs_together: assert property ($fell(lamp_en) |-> s_all_off)
    else $error("shutdown outputs not dropped together");
  a_power_stays_off: assert property (
    !machine_power_en |=> !machine_power_en)
    else $error("machine power returned without reset");
  a_coil_unpowered: assert property (!machine_power_en |-> s_all_off)
    else $error("outputs on while machine power removed");
  a_coil_after_reset: assert property (
    $rose(presetn) |-> !induction_heating_coil_en [*2])
    else $error("coil enabled before stored state loaded");
  a_ready_coil_off: assert property (
    $rose(ready) |-> ##[0:1] !induction_heating_coil_en)
    else $error("coil still on at ready temperature");
  a_ready_clears: assert property (
    $rose(ready) && nv_cnt_out <= 5'h01 |-> ##[0:2] nv_cnt_out == 5'h00)
    else $error("error counter not cleared at ready");
  a_hot_record: assert property (
    $rose(nv_code_out == 16'hC449) |-> s_hot_rec)
    else $error("overheat code stored with wrong counter");
  a_cnt_refused: assert property (
    psel && penable && pwrite && paddr == 8'h0C && pwdata >= 32'h0000001E
    |-> pslverr)
    else $error("out of range counter write accepted");
  a_stored_range: assert property (nv_wr |=> nv_cnt_out < 5'h1E)
    else $error("stored counter out of range");
endmodule // fts_chk
bind fts_top fts_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .nv_cnt_out, .nv_code_out, .nv_wr,
  .induction_heating_coil_en, .ready, .lamp_en, .panel_en, .motor_en,
  .machine_power_en);

// ---- tb/fts_sensor.sv ----
`timescale 1ns/1ps
module fts_sensor (
  input wire pclk,
  input wire [9:0] t_f,
  input wire [9:0] t_c,
  input wire [9:0] t_r,
  input wire [9:0] t_p,
  output logic adc_valid,
  output logic [9:0] adc_front,
  output logic [9:0] adc_center,
  output logic [9:0] adc_rear,
  output logic [9:0] adc_press,
  input wire nv_wr,
  input wire [4:0] nv_cnt_out,
  input wire [15:0] nv_code_out,
  output logic [4:0] nv_cnt_in,
  output logic [15:0] nv_code_in
);
  logic wr_d;
  // Storage starts empty once and is never touched by the block reset.
  initial begin
    {adc_valid, wr_d, nv_cnt_in, nv_code_in} = 23'h000000;
    {adc_front, adc_center, adc_rear, adc_press} = 40'h0000000000;
  end
  // A fresh set of four codes every other cycle, as a scanning converter.
  always @(posedge pclk) begin
    adc_valid <= !adc_valid;
    {adc_front, adc_center, adc_rear, adc_press} <= {t_f, t_c, t_r, t_p};
  end
  // The mirror is only valid a cycle after the pulse, so latch then.
  always @(posedge pclk) begin
    wr_d <= nv_wr;
    if (wr_d) begin
      {nv_cnt_in, nv_code_in} <= {nv_cnt_out, nv_code_out};
    end
  end
endmodule // fts_sensor

// ---- tb/fts_tb_top.sv ----
`timescale 1ns/1ps
module fts_tb_top;
  localparam logic [9:0] T100 = 10'h199;
  localparam logic [9:0] T170 = 10'h2E1;
  localparam logic [9:0] T230 = 10'h384;
  localparam logic [9:0] T275 = 10'h3FF;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, print_req = 1'h0, print_busy = 1'h1, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [9:0] t_f = T100, t_c = T100, t_r = T100, t_p = T100;
  wire [31:0] prdata;
  wire [9:0] adc_front, adc_center, adc_rear, adc_press;
  wire [4:0] nv_cnt_in, nv_cnt_out;
  wire [15:0] nv_code_in, nv_code_out;
  wire pready, pslverr, adc_valid, nv_wr, coil, ready, copy_pause;
  wire lamp_en, panel_en, motor_en, power_en;
  int n_errors = 0, checks = 0, i;
  always #12.5 pclk = ~pclk;
  fts_top #(.TICK_CYC(16'h0004), .MIN_TICKS(16'h0003),
    .WARM_TICKS(19'h00014)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_valid,
    .adc_front, .adc_center, .adc_rear, .adc_press, .print_req,
    .print_busy, .nv_cnt_in, .nv_code_in, .nv_cnt_out, .nv_code_out,
    .nv_wr, .induction_heating_coil_en(coil), .ready, .copy_pause,
    .lamp_en, .panel_en, .motor_en, .machine_power_en(power_en));
  fts_sensor i_far (.pclk, .t_f, .t_c, .t_r, .t_p, .adc_valid, .adc_front,
    .adc_center, .adc_rear, .adc_press, .nv_wr, .nv_cnt_out, .nv_code_out,
    .nv_cnt_in, .nv_code_in);
  task test_done;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask
  // One transfer plus an idle cycle, so back-to-back calls never collide.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin n_errors++; test_done; end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask
  task expect_reg(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h00000000);
    chk(rd, e);
  endtask
  task wait_stat(input logic [7:0] st);
    for (int k = 0; k < 300; k++) begin
      apb(1'h0, 8'h10, 32'h00000000);
      if (rd[7:0] === st) break;
    end
    chk(rd[7:0], st);
    if (rd[7:0] !== st) test_done;
  endtask
  task temps(input logic [9:0] f, c, r, p);
    t_f <= f; t_c <= c; t_r <= r; t_p <= p;
  endtask
  // A few spare cycles first let a pending store reach the storage.
  task do_reset;
    repeat (4) @(posedge pclk);
    presetn <= 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
  endtask
  task t_warm;
    wait_stat(8'h02);
    repeat (12) @(posedge pclk);
    chk(coil, 1'h1);
    temps(T230, T230, T230, T230);
    wait_stat(8'h04);
    repeat (12) @(posedge pclk);
    chk({ready, coil}, 2'h2);
    temps(T170, T230, T170, T230);
    repeat (12) @(posedge pclk);
    // Inside the band the coil is on again while the state stays ready.
    expect_reg(8'h10, 32'h00000304);
    chk(rd[7:0], 8'h04);
    expect_reg(8'h18, 32'h00AA00AA);
    expect_reg(8'h1C, 32'h00E600E6);
    apb(1'h1, 8'h00, 32'h00000001);
    wait_stat(8'h08);
    chk({copy_pause, ready}, 2'h2);
    temps(T230, T230, T230, T230);
    wait_stat(8'h04);
    apb(1'h1, 8'h00, 32'h00000000);
    $display("warm-up and band test done");
  endtask
  task t_regs;
    expect_reg(8'h04, 32'h0000000F);
    expect_reg(8'h08, 32'h0000005A);
    apb(1'h1, 8'h04, 32'h00000007);
    expect_reg(8'h04, 32'h00000007);
    apb(1'h1, 8'h0C, 32'h0000001E);
    chk(err, 1'h1);
    expect_reg(8'h0C, 32'h00000000);
    apb(1'h0, 8'h24, 32'h00000000);
    chk(err, 1'h1);
    chk(rd, 32'h00000000);
    apb(1'h1, 8'h04, 32'h0000000F);
    $display("register test done");
  endtask
  task t_idle;
    apb(1'h1, 8'h04, 32'h00000001);
    apb(1'h1, 8'h08, 32'h00000001);
    print_busy <= 1'h0;
    wait_stat(8'h10);
    chk(coil, 1'h0);
    wait_stat(8'h20);
    chk(coil, 1'h0);
    print_busy <= 1'h1;
    apb(1'h1, 8'h04, 32'h0000000F);
    apb(1'h1, 8'h08, 32'h0000005A);
    print_req <= 1'h1;
    @(posedge pclk);
    print_req <= 1'h0;
    wait_stat(8'h04);
    chk(ready, 1'h1);
    $display("idle test done");
  endtask
  task t_open;
    temps(10'h000, T230, T230, T230);
    wait_stat(8'h40);
    chk(coil, 1'h0);
    expect_reg(8'h14, 32'h0000C440);
    temps(T230, T230, T230, T230);
    // Let the good codes reach the block, or a tick re-raises the fault.
    repeat (4) @(posedge pclk);
    apb(1'h1, 8'h0C, 32'h00000000);
    expect_reg(8'h14, 32'h00000000);
    wait_stat(8'h04);
    $display("open thermistor test done");
  endtask
  // Two timed-out warm-ups in a row, then a power-on that must stay blocked.
  task t_warmfail;
    temps(T100, T100, T100, T100);
    for (i = 1; i <= 2; i++) begin
      do_reset;
      wait_stat(8'h40);
      expect_reg(8'h0C, i);
      expect_reg(8'h14, i == 1 ? 32'h0000C411 : 32'h0000C412);
    end
    do_reset;
    wait_stat(8'h40);
    chk(coil, 1'h0);
    expect_reg(8'h14, 32'h0000C412);
    temps(T230, T230, T230, T230);
    apb(1'h1, 8'h0C, 32'h00000001);
    do_reset;
    wait_stat(8'h04);
    expect_reg(8'h0C, 32'h00000000);
    $display("warm-up failure test done");
  endtask
  task t_hot;
    temps(T275, T230, T230, T230);
    wait_stat(8'h80);
    chk({lamp_en, panel_en, motor_en, coil}, 4'h0);
    expect_reg(8'h14, 32'h0000C449);
    expect_reg(8'h0C, 32'h00000009);
    repeat (12) @(posedge pclk);
    chk(power_en, 1'h0);
    do_reset;
    repeat (24) @(posedge pclk);
    chk(power_en, 1'h0);
    temps(T230, T230, T230, T275);
    do_reset;
    wait_stat(8'h80);
    expect_reg(8'h14, 32'h0000C468);
    expect_reg(8'h0C, 32'h00000008);
    temps(T230, T230, T230, T230);
    do_reset;
    wait_stat(8'h40);
    apb(1'h1, 8'h0C, 32'h00000000);
    wait_stat(8'h04);
    $display("overheat test done");
  endtask
  initial begin
    do_reset;
    t_warm;
    t_regs;
    t_idle;
    t_open;
    t_warmfail;
    t_hot;
    test_done;
  end
endmodule // fts_tb_top
